// ===== rtl/hpio_top.sv
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
// How it works
// - Four byte ports, groups A/B and C/D
// - Ports start as inputs reading pins
// - Output port drives written value, reads back
// - Direction bits 10,13 (A,B), 11,14 (C,D)
// - Clearing direction bit restores input, independently
// - Separate request and answer lines per group
// - Group direction bit sets handshake direction
// - Non-handshake ports keep basic input/output
// - Per-group invert bits for request, answer
// - Status shows pin levels and ready flags
// - Without handshake, answer follows manual bit
// - Clear bit returns group handshake to idle
// - After clear, direction must toggle to send
// - Init sequence leaves ports input, state clear
// - Request may come from counter or sync
// - Level, leading or trailing edge handshake modes
// - Output: ready set on peripheral request
// - Double buffered input latched on request edge
module hpio_top
    import hpio_pkg::*;
#(
    parameter int ANS_CYCLES = ANS_PULSE_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [31:0]          port_in,
    output logic      [31:0]          port_out,
    output logic      [31:0]          port_oe,
    input  wire logic                 strobe_in_g1,
    input  wire logic                 strobe_in_g2,
    input  wire logic [NGROUPS-1:0]   counter_req,
    input  wire logic [NGROUPS-1:0]   sync_req,
    output logic                      answer_out_g1,
    output logic                      answer_out_g2
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NGROUPS-1:0][REG_W-1:0]   setup;
        logic [REG_W-1:0]                dir;
        logic [31:0]                     drive;
        logic [NGROUPS-1:0][GROUP_W-1:0] buffer;
        logic [NGROUPS-1:0]              ready;
        logic [NGROUPS-1:0]              ans_int;
        logic [NGROUPS-1:0][CNT_W-1:0]   ans_cnt;
        logic [NGROUPS-1:0]              armed;
        logic [NGROUPS-1:0]              dir_prev;
        logic [NGROUPS-1:0]              req_prev;
        logic [NGROUPS-1:0]              answer;
        logic [31:0]                     rdata;
        logic                            ack;
    } hpio_state_s;

    hpio_state_s st;
    hpio_state_s next_st;

    // Direction bit position of each port
    function automatic int dir_pos(input int p);
        int r;
        r = DIR_A;
        unique case (p)
            0: r = DIR_A;
            1: r = DIR_B;
            2: r = DIR_C;
            default: r = DIR_D;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Bus decode, port data paths and both handshake groups
    always_comb begin
        logic                       req_take;
        logic [5:0]                 offs;
        logic [NGROUPS-1:0]         raw_pin;
        logic [NGROUPS-1:0]         raw_src;
        logic [NGROUPS-1:0]         req_eff;
        logic [NGROUPS-1:0]         req_ev;
        logic [NGROUPS-1:0]         hs_on;
        logic [NGROUPS-1:0]         gdir;
        logic [NGROUPS-1:0]         go;
        logic [NGROUPS-1:0]         grp_rd;
        logic [NGROUPS-1:0]         grp_wr;
        logic [NGROUPS-1:0]         hit;
        logic [NPORTS-1:0]          p_out;
        logic [NPORTS-1:0]          p_hs;
        logic [NPORTS-1:0]          p_dbl;
        logic [NPORTS*PORT_W-1:0]   pview;
        logic [REG_W-1:0]           status;
        logic                       pulse;
        logic                       trail;
        req_take = 1'b0;
        offs     = 6'h00;
        raw_pin  = '0;
        raw_src  = '0;
        req_eff  = '0;
        req_ev   = '0;
        hs_on    = '0;
        gdir     = '0;
        go       = '0;
        grp_rd   = '0;
        grp_wr   = '0;
        hit      = '0;
        p_out    = '0;
        p_hs     = '0;
        p_dbl    = '0;
        pview    = '0;
        status   = '0;
        pulse    = 1'b0;
        trail    = 1'b0;
        next_st  = st;

        // Single-cycle classic bus: answer one edge after the request
        req_take    = wb_cyc_i && wb_stb_i && !st.ack;
        offs        = {wb_adr_i[ADR_W-1:2], 2'b00};
        next_st.ack = req_take;

        raw_pin = {strobe_in_g2, strobe_in_g1};

        // Per-port direction and handshake view
        for (int p = 0; p < NPORTS; p++) begin
            p_out[p] = st.dir[dir_pos(p)];
            p_hs[p]  = st.setup[p/2][(p%2 == 0) ? SU_HS_ON_LO : SU_HS_ON_HI];
            p_dbl[p] = st.setup[p/2][(p%2 == 0) ? SU_DBUF_LO : SU_DBUF_HI];
            // Output reads back the driven byte, input reads pins or buffer
            if (p_out[p]) begin
                pview[p*PORT_W +: PORT_W] = st.drive[p*PORT_W +: PORT_W];
            end else if (p_hs[p] && p_dbl[p]) begin
                pview[p*PORT_W +: PORT_W] = st.buffer[p/2][(p%2)*PORT_W +: PORT_W];
            end else begin
                pview[p*PORT_W +: PORT_W] = port_in[p*PORT_W +: PORT_W];
            end
        end

        // Group access detection: a touched byte of an enabled port
        for (int g = 0; g < NGROUPS; g++) begin
            hit[g] = req_take && (offs == ((g == 0) ? OFF_PORTS_AB : OFF_PORTS_CD)) &&
                     ((p_hs[2*g] && wb_sel_i[0]) ||                    // Low port, lane 0
                      (p_hs[2*g+1] && wb_sel_i[1]));                   // High port, lane 1
            grp_rd[g] = hit[g] && !wb_we_i;
            grp_wr[g] = hit[g] && wb_we_i;
        end

        // Register writes
        if (req_take && wb_we_i) begin
            for (int b = 0; b < 2; b++) begin
                if (wb_sel_i[b]) begin
                    if (offs == OFF_G1_SETUP) next_st.setup[0][b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    if (offs == OFF_G2_SETUP) next_st.setup[1][b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    if (offs == OFF_DIRECTION) next_st.dir[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
            // Port words: A/B in the low halves, C/D likewise
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b] && offs == OFF_PORTS_AB && b < 2) begin
                    next_st.drive[b*PORT_W +: PORT_W] = wb_dat_i[b*PORT_W +: PORT_W];
                end
                if (wb_sel_i[b] && offs == OFF_PORTS_CD && b < 2) begin
                    next_st.drive[GROUP_W + b*PORT_W +: PORT_W] = wb_dat_i[b*PORT_W +: PORT_W];
                end
            end
        end

        // Handshake groups
        for (int g = 0; g < NGROUPS; g++) begin
            pulse = st.setup[g][SU_PULSE];
            trail = pulse && st.setup[g][SU_EDGE];
            hs_on[g] = p_hs[2*g] || p_hs[2*g+1];
            gdir[g]  = p_hs[2*g] ? p_out[2*g] : p_out[2*g+1];
            // Request source: own pin, counter or sync bus
            unique case (st.setup[g][SU_SRC_LSB +: SU_SRC_W])
                SRC_COUNTER: raw_src[g] = counter_req[g];
                SRC_SYNC:    raw_src[g] = sync_req[g];
                default:     raw_src[g] = raw_pin[g];
            endcase
            req_eff[g] = raw_src[g] ^ st.setup[g][SU_INV_STROBE];
            // Trailing edge on fall, level and leading on rise
            req_ev[g]  = trail ? (st.req_prev[g] && !req_eff[g])
                               : (!st.req_prev[g] && req_eff[g]);
            go[g] = gdir[g] && !st.dir_prev[g] && hs_on[g];
            next_st.req_prev[g] = req_eff[g];
            next_st.dir_prev[g] = gdir[g];

            if (st.setup[g][SU_CLEAR]) begin
                // Held idle while the clear bit stands
                next_st.ready[g]   = 1'b0;
                next_st.ans_int[g] = 1'b0;
                next_st.ans_cnt[g] = '0;
                next_st.armed[g]   = 1'b0;
                next_st.buffer[g]  = '0;
            end else begin
                if (go[g]) begin
                    next_st.armed[g] = 1'b1;
                end
                // Answer timing: pulse modes time out, level waits for request
                if (pulse) begin
                    if (st.ans_cnt[g] > CNT_W'(1)) begin
                        next_st.ans_cnt[g] = st.ans_cnt[g] - CNT_W'(1);
                    end else begin
                        next_st.ans_cnt[g] = '0;
                        next_st.ans_int[g] = 1'b0;
                    end
                end else if (req_ev[g]) begin
                    next_st.ans_int[g] = 1'b0;
                end
                // Software access of an enabled port completes the word
                if (hs_on[g] && st.ready[g] &&
                    ((gdir[g] && grp_wr[g]) || (!gdir[g] && grp_rd[g]))) begin
                    next_st.ready[g]   = 1'b0;
                    next_st.ans_int[g] = 1'b1;
                    next_st.ans_cnt[g] = CNT_W'(ANS_CYCLES);
                end
                // Peripheral request sets ready; set beats clear
                if (hs_on[g] && !gdir[g] && req_ev[g]) begin
                    next_st.ready[g]  = 1'b1;
                    next_st.buffer[g] = port_in[g*GROUP_W +: GROUP_W];
                end
                if (hs_on[g] && gdir[g] && (st.armed[g] || go[g]) &&
                    (req_ev[g] || (go[g] && req_eff[g]))) begin
                    next_st.ready[g] = 1'b1;
                end
            end
            // Answer pin: handshake state or manual level
            next_st.answer[g] = hs_on[g] ? (next_st.ans_int[g] ^ st.setup[g][SU_INV_ANSWER])
                                         : st.setup[g][SU_MANUAL_ANS];
            status[g*STAT_STRIDE + STAT_REQ]   = raw_pin[g];
            status[g*STAT_STRIDE + STAT_ANS]   = st.answer[g];
            status[g*STAT_STRIDE + STAT_READY] = st.ready[g];
        end

        // Read data, unmapped offsets read zero
        next_st.rdata = '0;
        if (req_take && !wb_we_i) begin
            unique case (offs)
                OFF_PORTS_AB:  next_st.rdata = {16'h0000, pview[15:0]};
                OFF_PORTS_CD:  next_st.rdata = {16'h0000, pview[31:16]};
                OFF_G1_SETUP:  next_st.rdata = {16'h0000, st.setup[0]};
                OFF_G2_SETUP:  next_st.rdata = {16'h0000, st.setup[1]};
                OFF_DIRECTION: next_st.rdata = {16'h0000, st.dir};
                OFF_STATUS:    next_st.rdata = {16'h0000, status};
                default:       next_st.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Synchronous reset to all-input, idle state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st          <= '0;
            st.setup[0] <= SETUP_RST;
            st.setup[1] <= SETUP_RST;
            st.dir      <= DIR_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pin drivers, one byte enable group per port
    always_comb begin
        for (int p = 0; p < NPORTS; p++) begin
            port_oe[p*PORT_W +: PORT_W] = {PORT_W{st.dir[dir_pos(p)]}};
        end
    end

    assign port_out      = st.drive;
    assign wb_dat_o      = st.rdata;
    assign wb_ack_o      = st.ack;
    assign answer_out_g1 = st.answer[0];
    assign answer_out_g2 = st.answer[1];

endmodule

// ===== pkg/hpio_pkg.sv
package hpio_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PORT_W   = 8;
    localparam int NPORTS   = 4;
    localparam int NGROUPS  = 2;
    localparam int GROUP_W  = 16;
    localparam int REG_W    = 16;
    localparam int ADR_W    = 6;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_PORTS_AB  = 6'h00;
    localparam logic [5:0] OFF_PORTS_CD  = 6'h04;
    localparam logic [5:0] OFF_G1_SETUP  = 6'h08;
    localparam logic [5:0] OFF_G2_SETUP  = 6'h0c;
    localparam logic [5:0] OFF_DIRECTION = 6'h10;
    localparam logic [5:0] OFF_STATUS    = 6'h14;

    // ------------------------------------------------------------
    // Group setup register fields
    // ------------------------------------------------------------
    localparam int SU_PULSE      = 0;
    localparam int SU_EDGE       = 1;
    localparam int SU_INV_ANSWER = 2;
    localparam int SU_MANUAL_ANS = 3;
    localparam int SU_DBUF_LO    = 4;
    localparam int SU_DBUF_HI    = 5;
    localparam int SU_INV_STROBE = 6;
    localparam int SU_CLEAR      = 8;
    localparam int SU_HS_ON_LO   = 9;
    localparam int SU_HS_ON_HI   = 10;
    localparam int SU_SRC_LSB    = 11;
    localparam int SU_SRC_W      = 2;

    // Request source choices
    localparam logic [1:0] SRC_PIN     = 2'h0;
    localparam logic [1:0] SRC_COUNTER = 2'h1;
    localparam logic [1:0] SRC_SYNC    = 2'h2;

    // Direction register bit of ports A, B, C, D
    localparam int DIR_A = 10;
    localparam int DIR_B = 13;
    localparam int DIR_C = 11;
    localparam int DIR_D = 14;

    // Status register layout, per group at GROUP*STAT_STRIDE
    localparam int STAT_STRIDE = 4;
    localparam int STAT_REQ    = 0;
    localparam int STAT_ANS    = 1;
    localparam int STAT_READY  = 2;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] SETUP_RST = 16'h0000;
    localparam logic [15:0] DIR_RST   = 16'h0000;
    localparam int CLK_MHZ          = 100;
    localparam int ANS_PULSE_NS     = 100;
    localparam int ANS_PULSE_CYCLES = (ANS_PULSE_NS * CLK_MHZ) / 1000;
    localparam int CNT_W            = 8;

endpackage

// ===== testbench/hpio_properties.sv
`timescale 1ns/1ns
module hpio_properties
    import hpio_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [31:0] port_in,
    input wire logic [31:0] port_out,
    input wire logic [31:0] port_oe,
    input wire logic        strobe_in_g1,
    input wire logic        strobe_in_g2,
    input wire logic [1:0]  counter_req,
    input wire logic [1:0]  sync_req,
    input wire logic        answer_out_g1,
    input wire logic        answer_out_g2
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [15:0] su2;
    logic [1:0]  quiet;
    wire logic [3:0] wa = wb_adr_i[5:2];
    wire logic dir_req = wb_cyc_i && wb_stb_i && wb_we_i && wa == OFF_DIRECTION[5:2];
    // Group 2 setup copy, cycles since its last write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            su2 <= 16'h0000;
            quiet <= 2'h0;
        end else if (wb_ack_o && wb_we_i && wa == OFF_G2_SETUP[5:2]) begin
            su2 <= wb_dat_i[15:0];
            quiet <= 2'h0;
        end else if (quiet != 2'h3) begin
            quiet <= quiet + 2'h1;
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer too long");
    a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside answer");
    a_reset_quiet: assert property ($fell(reset) |-> port_oe == 32'h0 && !answer_out_g1 && !answer_out_g2)
        else $error("state after reset wrong");
    a_dir_decode: assert property (wb_ack_o && wb_we_i && wb_sel_i[1] && wa == OFF_DIRECTION[5:2] |->
        port_oe == {{8{wb_dat_i[14]}}, {8{wb_dat_i[11]}}, {8{wb_dat_i[13]}}, {8{wb_dat_i[10]}}})
        else $error("direction decode wrong");
    a_oe_cause: assert property ($changed(port_oe) |-> $past(dir_req))
        else $error("direction moved alone");
    a_port_drive: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wa == OFF_PORTS_AB[5:2] && port_oe[0]
        |-> port_out[7:0] == wb_dat_i[7:0])
        else $error("written value not driven");
    a_stat_pins: assert property (wb_ack_o && !wb_we_i && wa == OFF_STATUS[5:2] && $stable(strobe_in_g1)
        && $stable(strobe_in_g2) |-> wb_dat_o[0] == strobe_in_g1 && wb_dat_o[4] == strobe_in_g2)
        else $error("status request bits wrong");
    a_manual_ans: assert property (quiet == 2'h3 && su2[10:8] == 3'h0 |-> answer_out_g2 == su2[3])
        else $error("manual answer not followed");
    c_ready: cover property (wb_ack_o && !wb_we_i && wa == OFF_STATUS[5:2] && wb_dat_o[2]);
    c_answer: cover property ($rose(answer_out_g1));
    c_out: cover property (wb_ack_o && wb_we_i && wa == OFF_PORTS_CD[5:2] && port_oe[16]);
endmodule

// ===== testbench/hpio_periph.sv
`timescale 1ns/1ns
// ----------------------------------------
// Far-side peripheral of one group
// ----------------------------------------
module hpio_periph (
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic [15:0] word,
    input  wire logic        inv_req,
    input  wire logic        inv_ans,
    input  wire logic [3:0]  lag,
    input  wire logic        answer,
    input  wire logic [15:0] drv,
    output logic             strobe,
    output logic [15:0]      lines,
    output logic [15:0]      got,
    output logic             busy,
    output logic             seen
);
    logic act;
    int   n;
    // Request pin after polarity
    assign strobe = act ^ inv_req;
    // Data, held request, then wait for the answer
    initial begin
        act = 1'b0;
        lines = 16'h0000;
        got = 16'h0000;
        busy = 1'b0;
        seen = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (go === 1'b1) begin
                busy <= 1'b1;
                repeat (lag) @(posedge ref_clk);
                lines <= word;
                @(posedge ref_clk);
                act <= 1'b1;
                repeat (6) @(posedge ref_clk);
                act <= 1'b0;
                for (n = 0; (answer ^ inv_ans) !== 1'b1 && n < 60; n++) @(posedge ref_clk);
                seen <= (answer ^ inv_ans) === 1'b1;
                got <= drv;
                lines <= ~word;
                busy <= 1'b0;
            end
        end
    end
endmodule

// ===== testbench/hpio_top_tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the handshaked ports
// ----------------------------------------
module hpio_top_tb;
    import hpio_pkg::*;
    logic        ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [5:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, q, v, m, seed;
    logic [1:0]  counter_req, sync_req, go, inv_req, inv_ans;
    logic [15:0] word [2];
    logic [15:0] cfg;
    logic [3:0]  lag [2];
    logic [5:0]  offs [4] = '{OFF_G1_SETUP, OFF_G2_SETUP, OFF_DIRECTION, 6'h18};
    wire  [31:0] wb_dat_o, port_in, port_out, port_oe;
    wire  [15:0] got [2];
    wire  [1:0]  stb, busy, seen;
    wire         wb_ack_o, answer_out_g1, answer_out_g2;
    int          num_errors, comparisons;

    hpio_top #(.ANS_CYCLES(2)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .strobe_in_g1(stb[0]), .strobe_in_g2(stb[1]),
        .counter_req(counter_req), .sync_req(sync_req), .answer_out_g1(answer_out_g1),
        .answer_out_g2(answer_out_g2));
    for (genvar g = 0; g < 2; g++) begin : g_per
        hpio_periph i_per (.ref_clk(ref_clk), .go(go[g]), .word(word[g]), .inv_req(inv_req[g]),
            .inv_ans(inv_ans[g]), .lag(lag[g]), .answer(g ? answer_out_g2 : answer_out_g1),
            .drv(port_out[16*g+:16]), .strobe(stb[g]), .lines(port_in[16*g+:16]), .got(got[g]),
            .busy(busy[g]), .seen(seen[g]));
    end
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask
    task automatic results();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic fail();
        num_errors++;
        results();
    endtask
    // Expected pin enables from a direction word
    function automatic logic [31:0] oe_mask(input logic [15:0] d);
        return {{8{d[DIR_D]}}, {8{d[DIR_C]}}, {8{d[DIR_B]}}, {8{d[DIR_A]}}};
    endfunction
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) fail();
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        bus(1'b1, a, {16'h0, d});
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 40);
        if (q[b] !== 1'b1) fail();
    endtask
    task xfer(input int g, input logic [15:0] w);
        word[g] <= w;
        lag[g] <= 4'($random(seed));
        go[g] <= 1'b1;
        @(posedge ref_clk);
        go[g] <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic idle(input int g);
        int n;
        for (n = 0; busy[g] !== 1'b0 && n < 200; n++) @(posedge ref_clk);
        if (busy[g] !== 1'b0) fail();
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hc2a7217e;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {counter_req, sync_req, go, inv_req, inv_ans} = '0;
        word = '{default: 16'h0};
        lag = '{default: 4'h0};
        num_errors = 0;
        comparisons = 0;
        reset = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        // Reset state
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, offs[i], 32'h0);
            chk(q, 32'h0);
        end
        bus(1'b0, OFF_PORTS_AB, 32'h0);
        chk(q, {16'h0, port_in[15:0]});
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(q & 32'h33, {27'h0, stb[1], 3'h0, stb[0]});
        // Basic input and output, random directions
        for (int k = 0; k < 8; k++) begin
            v = (k == 0) ? 32'h6c00 : (k == 7) ? 32'h0 : ($random(seed) & 32'h6c00);
            wr(OFF_DIRECTION, v[15:0]);
            m = oe_mask(v[15:0]);
            chk(port_oe, m);
            v = $random(seed);
            wr(OFF_PORTS_AB, v[15:0]);
            wr(OFF_PORTS_CD, v[31:16]);
            bus(1'b0, OFF_PORTS_AB, 32'h0);
            chk(q, {16'h0, (v[15:0] & m[15:0]) | (port_in[15:0] & ~m[15:0])});
            bus(1'b0, OFF_PORTS_CD, 32'h0);
            chk(q, {16'h0, (v[31:16] & m[31:16]) | (port_in[31:16] & ~m[31:16])});
        end
        // Group 1 16-bit input, all modes and polarities
        for (int k = 0; k < 6; k++) begin
            cfg = 16'h0630 | ((k % 3 == 0) ? 16'h0 : (k % 3 == 1) ? 16'h1 : 16'h3) | ((k > 2) ? 16'h44 : 16'h0);
            wr(OFF_G1_SETUP, cfg | 16'h0100);
            inv_req[0] <= k > 2;
            inv_ans[0] <= k > 2;
            wr(OFF_G1_SETUP, cfg);
            v = $random(seed);
            xfer(0, v[15:0]);
            poll(2);
            chk(q & 32'h4, 32'h4);
            bus(1'b0, OFF_PORTS_AB, 32'h0);
            chk(q, {16'h0, v[15:0]});
            bus(1'b0, OFF_STATUS, 32'h0);
            chk(q & 32'h4, 32'h0);
            idle(0);
            chk(seen[0], 1'b1);
        end
        // Counter and sync request sources
        inv_req[0] <= 1'b0;
        inv_ans[0] <= 1'b0;
        for (int s = 1; s < 3; s++) begin
            cfg = 16'h0600 | 16'(s << 11);
            wr(OFF_G1_SETUP, cfg | 16'h0100);
            wr(OFF_G1_SETUP, cfg);
            counter_req[0] <= s == 1;
            sync_req[0] <= s == 2;
            repeat (3) @(posedge ref_clk);
            counter_req <= 2'h0;
            sync_req <= 2'h0;
            poll(2);
            chk(q & 32'h4, 32'h4);
            bus(1'b0, OFF_PORTS_AB, 32'h0);
        end
        // Port C 8-bit output, clear then re-arm
        wr(OFF_G2_SETUP, 16'h0200);
        wr(OFF_DIRECTION, 16'h0800);
        wr(OFF_G2_SETUP, 16'h0300);
        wr(OFF_G2_SETUP, 16'h0200);
        xfer(1, 16'h0);
        idle(1);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(q & 32'h40, 32'h0);
        wr(OFF_DIRECTION, 16'h0000);
        wr(OFF_DIRECTION, 16'h0800);
        repeat (4) begin
            xfer(1, 16'($random(seed)));
            poll(6);
            chk(q & 32'h40, 32'h40);
            v = $random(seed);
            wr(OFF_PORTS_CD, v[15:0]);
            idle(1);
            chk(got[1][7:0], v[7:0]);
            bus(1'b0, OFF_PORTS_CD, 32'h0);
            chk(q, {16'h0, port_in[31:24], v[7:0]});
        end
        // Manual answer line
        wr(OFF_G2_SETUP, 16'h0008);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk({answer_out_g2, q[5]}, 2'h3);
        wr(OFF_G2_SETUP, 16'h0000);
        chk(answer_out_g2, 1'b0);
        // Start-up sequence with a transfer pending
        wr(OFF_G1_SETUP, 16'h0600);
        xfer(0, 16'($random(seed)));
        idle(0);
        wr(OFF_G1_SETUP, 16'h0100);
        wr(OFF_G2_SETUP, 16'h0100);
        wr(OFF_DIRECTION, 16'h0000);
        wr(OFF_G1_SETUP, 16'h0000);
        wr(OFF_G2_SETUP, 16'h0000);
        chk(port_oe, 32'h0);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(q & 32'h44, 32'h0);
        results();
    end
endmodule

bind hpio_top hpio_properties i_prop (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .strobe_in_g1(strobe_in_g1),
    .strobe_in_g2(strobe_in_g2), .counter_req(counter_req), .sync_req(sync_req),
    .answer_out_g1(answer_out_g1), .answer_out_g2(answer_out_g2));
